/* lts_pkg.sv */
// Purpose: Shared constants for the link training status report block
// Assumes: 32-bit AXI4-Lite register words, one aligned word per register
// Notes:   Training-state codes are grouped into coarse phases by range
package lts_pkg;
  // --------------------------------------------------------------------
  // Register map and fields
  // --------------------------------------------------------------------
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_CHG = 8'h08;
  localparam logic [7:0] OFF_RECOV = 8'h0c;
  localparam logic [7:0] OFF_L0S = 8'h10;
  localparam int ST_FSM_LSB = 0;
  localparam int ST_LANES_LSB = 8;
  localparam int ST_RXLP_LSB = 12;
  localparam int ST_TXLP_LSB = 16;
  localparam int ST_PHASE_LSB = 20;
  localparam int ST_LINKUP_BIT = 24;
  localparam int CT_REQ_LSB = 0;
  localparam int CT_RATE_BIT = 2;
  localparam int CT_LANES_LSB = 4;
  localparam int CT_REASON_BIT = 8;
  localparam int CG_BUSY_BIT = 0;
  localparam int CG_DONE_BIT = 1;
  localparam int CG_REFUSED_BIT = 2;
  localparam int CG_ABORT_BIT = 3;
  localparam int CG_LINKDROP_BIT = 4;
  localparam logic [8:0] CTRL_RST = 9'h000;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // --------------------------------------------------------------------
  // Training-state codes
  // --------------------------------------------------------------------
  localparam logic [5:0] FSM_DET_QUIET = 6'h00;
  localparam logic [5:0] FSM_DET_ACT_END = 6'h03;
  localparam logic [5:0] FSM_POLL_ACT = 6'h04;
  localparam logic [5:0] FSM_POLL_CFG = 6'h05;
  localparam logic [5:0] FSM_COMP_FIRST = 6'h06;
  localparam logic [5:0] FSM_COMP_LAST = 6'h0a;
  localparam logic [5:0] FSM_CFG_FIRST = 6'h0b;
  localparam logic [5:0] FSM_CFG_IDLE = 6'h15;
  localparam logic [5:0] FSM_L0 = 6'h16;
  localparam logic [5:0] FSM_L1_FIRST = 6'h17;
  localparam logic [5:0] FSM_L1_EXIT = 6'h1b;
  localparam logic [5:0] FSM_RCV_LOCK = 6'h1c;
  localparam logic [5:0] FSM_RCV_IDLE = 6'h20;
  localparam logic [5:0] FSM_HOT_RESET = 6'h21;
  localparam logic [5:0] FSM_DIS_FIRST = 6'h22;
  localparam logic [5:0] FSM_DIS_IDLE = 6'h25;
  localparam logic [5:0] FSM_RP_CFG_FIRST = 6'h26;
  localparam logic [5:0] FSM_RP_CFG_LAST = 6'h2c;
  localparam logic [5:0] FSM_TIMEOUT_DET = 6'h2d;
  localparam logic [5:0] FSM_LPBK_FIRST = 6'h2e;
  localparam logic [5:0] FSM_LPBK_LAST = 6'h32;
  // Other encodings
  localparam logic [1:0] LANES_X1 = 2'b00;
  localparam logic [1:0] RX_LP_OFF = 2'b00;
  localparam logic [2:0] TX_LP_OFF = 3'b000;
  localparam logic [1:0] CHG_NONE = 2'b00;
  typedef enum logic [3:0] {
    PH_DETECT = 4'h0, PH_POLLING = 4'h1, PH_COMPLIANCE = 4'h2,
    PH_CONFIG = 4'h3, PH_L0 = 4'h4, PH_L1 = 4'h5, PH_RECOVERY = 4'h6,
    PH_HOT_RESET = 4'h7, PH_DISABLED = 4'h8, PH_TIMEOUT = 4'h9,
    PH_LOOPBACK = 4'ha, PH_UNKNOWN = 4'hf
  } lts_phase_t;
  typedef enum logic {CS_IDLE = 1'b0, CS_ACTIVE = 1'b1} lts_chg_state_t;
endpackage

/* lts_axil_slave.sv */
// Purpose: AXI4-Lite slave front end, one write and one read at a time
// Assumes: Register logic answers errors combinationally on the strobe
// Notes:   Write answer one edge after both channels taken
`timescale 1ns/1ps
module lts_axil_slave
  import lts_pkg::*;
#(
  parameter int AW = 8
)
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [AW-1:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  input wire logic [AW-1:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  output logic wr_en_o,
  output logic [AW-1:0] wr_addr_o,
  output logic [31:0] wr_data_o,
  output logic [3:0] wr_strb_o,
  input wire logic wr_err_i,
  output logic rd_en_o,
  output logic [AW-1:0] rd_addr_o,
  input wire logic [31:0] rd_data_i,
  input wire logic rd_err_i
);
  logic aw_full_r, w_full_r, ar_full_r;
  // Channels held off while an answer is pending
  assign awready_o = !aw_full_r && !bvalid_o;
  assign wready_o = !w_full_r && !bvalid_o;
  assign wr_en_o = aw_full_r && w_full_r && !bvalid_o;
  assign arready_o = !ar_full_r && !rvalid_o;
  assign rd_en_o = ar_full_r;
  // Write address capture
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
    begin
      aw_full_r <= 1'b0;
      wr_addr_o <= '0;
    end
    else if (awvalid_i && awready_o)
    begin
      aw_full_r <= 1'b1;
      wr_addr_o <= awaddr_i;
    end
    else if (wr_en_o)
      aw_full_r <= 1'b0;
  // Write data capture, either order against the address
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
    begin
      w_full_r <= 1'b0;
      wr_data_o <= '0;
      wr_strb_o <= '0;
    end
    else if (wvalid_i && wready_o)
    begin
      w_full_r <= 1'b1;
      wr_data_o <= wdata_i;
      wr_strb_o <= wstrb_i;
    end
    else if (wr_en_o)
      w_full_r <= 1'b0;
  // Write response
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
    begin
      bvalid_o <= 1'b0;
      bresp_o <= RESP_OKAY;
    end
    else if (wr_en_o)
    begin
      bvalid_o <= 1'b1;
      bresp_o <= wr_err_i ? RESP_SLVERR : RESP_OKAY;
    end
    else if (bready_i)
      bvalid_o <= 1'b0;
  // Read address capture
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
    begin
      ar_full_r <= 1'b0;
      rd_addr_o <= '0;
    end
    else if (arvalid_i && arready_o)
    begin
      ar_full_r <= 1'b1;
      rd_addr_o <= araddr_i;
    end
    else
      ar_full_r <= 1'b0;
  // Read data registered from the decode
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
    begin
      rvalid_o <= 1'b0;
      rdata_o <= '0;
      rresp_o <= RESP_OKAY;
    end
    else if (rd_en_o)
    begin
      rvalid_o <= 1'b1;
      rdata_o <= rd_data_i;
      rresp_o <= rd_err_i ? RESP_SLVERR : RESP_OKAY;
    end
    else if (rready_i)
      rvalid_o <= 1'b0;
endmodule

/* lts_change_ctl.sv */
// Purpose: Sequencer for one directed width or speed change
// Assumes: Core raises its done level or pulse when the change completes
// Notes:   Request level held until done, dropped one edge after link_up_i falls
`timescale 1ns/1ps
module lts_change_ctl
  import lts_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic start_i,
  input wire logic [1:0] kind_i,
  input wire logic link_up_i,
  input wire logic core_done_i,
  output logic [1:0] request_o,
  output logic busy_o,
  output logic done_o,
  output logic abort_o,
  output logic refused_o
);
  lts_chg_state_t state_r;
  logic [1:0] kind_r;
  // Level request only while active
  assign busy_o = (state_r == CS_ACTIVE);
  assign request_o = busy_o ? kind_r : CHG_NONE;
  // Sequencer and event pulses
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
    begin
      state_r <= CS_IDLE;
      kind_r <= CHG_NONE;
      done_o <= 1'b0;
      abort_o <= 1'b0;
      refused_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      abort_o <= 1'b0;
      refused_o <= 1'b0;
      unique case (state_r)
        CS_IDLE:
        begin
          if (start_i && link_up_i)
          begin
            state_r <= CS_ACTIVE;
            kind_r <= kind_i;
          end
          else if (start_i)
            refused_o <= 1'b1; // Change only with link up
        end
        CS_ACTIVE:
        begin
          if (!link_up_i)
          begin
            state_r <= CS_IDLE;
            abort_o <= 1'b1;
          end
          else if (core_done_i)
          begin
            state_r <= CS_IDLE;
            done_o <= 1'b1;
          end
        end
      endcase
    end
endmodule

/* lts_report.sv */
// Purpose: Physical-layer status report and directed change control
// Assumes: Core status inputs are on clk_i; AXI4-Lite from software
// Notes:   Control writes refused while a change is under way
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module lts_report
  import lts_pkg::*;
#(
  parameter int AW = 8,
  parameter int CNT_W = 16
)
(
  input wire logic clk_i,
  input wire logic nrst_i,
  // AXI4-Lite slave
  input wire logic [AW-1:0] s_axil_awaddr_i,
  input wire logic s_axil_awvalid_i,
  output logic s_axil_awready_o,
  input wire logic [31:0] s_axil_wdata_i,
  input wire logic [3:0] s_axil_wstrb_i,
  input wire logic s_axil_wvalid_i,
  output logic s_axil_wready_o,
  output logic [1:0] s_axil_bresp_o,
  output logic s_axil_bvalid_o,
  input wire logic s_axil_bready_i,
  input wire logic [AW-1:0] s_axil_araddr_i,
  input wire logic s_axil_arvalid_i,
  output logic s_axil_arready_o,
  output logic [31:0] s_axil_rdata_o,
  output logic [1:0] s_axil_rresp_o,
  output logic s_axil_rvalid_o,
  input wire logic s_axil_rready_i,
  // Status from the physical layer
  input wire logic core_link_up_i,
  input wire logic [1:0] core_lane_count_i,
  input wire logic [5:0] core_fsm_state_i,
  input wire logic [1:0] core_rx_lp_i,
  input wire logic [2:0] core_tx_lp_i,
  input wire logic core_change_done_i,
  // Registered status view
  output logic link_up_o,
  output logic [1:0] current_lane_count_o,
  output logic [5:0] training_fsm_state_o,
  output logic [1:0] rx_low_power_state_o,
  output logic [2:0] tx_low_power_state_o,
  output logic [3:0] link_phase_o,
  // Directed change toward the physical layer
  output logic [1:0] directed_change_request_o,
  output logic directed_target_rate_o,
  output logic [1:0] directed_target_lanes_o,
  output logic directed_change_reason_o,
  output logic directed_change_finished_o
);
  // --------------------------------------------------------------------
  // Decode helpers
  // --------------------------------------------------------------------
  // Coarse phase of a training-state code
  function automatic lts_phase_t phase_of(input logic [5:0] code);
    lts_phase_t ph;
    ph = PH_UNKNOWN;
    if (code <= FSM_DET_ACT_END)
      ph = PH_DETECT;
    else if (code == FSM_POLL_ACT || code == FSM_POLL_CFG)
      ph = PH_POLLING;
    else if (code >= FSM_COMP_FIRST && code <= FSM_COMP_LAST)
      ph = PH_COMPLIANCE;
    else if (code >= FSM_CFG_FIRST && code <= FSM_CFG_IDLE)
      ph = PH_CONFIG;
    else if (code == FSM_L0)
      ph = PH_L0;
    else if (code >= FSM_L1_FIRST && code <= FSM_L1_EXIT)
      ph = PH_L1;
    else if (code >= FSM_RCV_LOCK && code <= FSM_RCV_IDLE)
      ph = PH_RECOVERY;
    else if (code == FSM_HOT_RESET)
      ph = PH_HOT_RESET;
    else if (code >= FSM_DIS_FIRST && code <= FSM_DIS_IDLE)
      ph = PH_DISABLED;
    else if (code >= FSM_RP_CFG_FIRST && code <= FSM_RP_CFG_LAST)
      ph = PH_CONFIG;
    else if (code == FSM_TIMEOUT_DET)
      ph = PH_TIMEOUT;
    else if (code >= FSM_LPBK_FIRST && code <= FSM_LPBK_LAST)
      ph = PH_LOOPBACK;
    return ph;
  endfunction

  // Register index from a byte address, seven for unmapped
  typedef enum logic [2:0] {
    RI_STATUS = 3'h0, RI_CTRL = 3'h1, RI_CHG = 3'h2,
    RI_RECOV = 3'h3, RI_L0S = 3'h4, RI_NONE = 3'h7
  } lts_reg_idx_t;
  function automatic lts_reg_idx_t reg_of(input logic [AW-1:0] addr);
    lts_reg_idx_t ri;
    ri = RI_NONE;
    if (addr == AW'(OFF_STATUS))
      ri = RI_STATUS;
    else if (addr == AW'(OFF_CTRL))
      ri = RI_CTRL;
    else if (addr == AW'(OFF_CHG))
      ri = RI_CHG;
    else if (addr == AW'(OFF_RECOV))
      ri = RI_RECOV;
    else if (addr == AW'(OFF_L0S))
      ri = RI_L0S;
    return ri;
  endfunction

  // --------------------------------------------------------------------
  // Bus front end
  // --------------------------------------------------------------------
  logic wr_en, rd_en, wr_err, rd_err;
  logic [AW-1:0] wr_addr, rd_addr;
  logic [31:0] wr_data, rd_data;
  logic [3:0] wr_strb;
  lts_reg_idx_t wr_idx, rd_idx;
  logic chg_busy, chg_done, chg_abort, chg_refused;
  logic [1:0] chg_request;

  lts_axil_slave #(.AW(AW)) u_bus
  (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .awaddr_i(s_axil_awaddr_i),
    .awvalid_i(s_axil_awvalid_i),
    .awready_o(s_axil_awready_o),
    .wdata_i(s_axil_wdata_i),
    .wstrb_i(s_axil_wstrb_i),
    .wvalid_i(s_axil_wvalid_i),
    .wready_o(s_axil_wready_o),
    .bresp_o(s_axil_bresp_o),
    .bvalid_o(s_axil_bvalid_o),
    .bready_i(s_axil_bready_i),
    .araddr_i(s_axil_araddr_i),
    .arvalid_i(s_axil_arvalid_i),
    .arready_o(s_axil_arready_o),
    .rdata_o(s_axil_rdata_o),
    .rresp_o(s_axil_rresp_o),
    .rvalid_o(s_axil_rvalid_o),
    .rready_i(s_axil_rready_i),
    .wr_en_o(wr_en),
    .wr_addr_o(wr_addr),
    .wr_data_o(wr_data),
    .wr_strb_o(wr_strb),
    .wr_err_i(wr_err),
    .rd_en_o(rd_en),
    .rd_addr_o(rd_addr),
    .rd_data_i(rd_data),
    .rd_err_i(rd_err)
  );

  assign wr_idx = reg_of(wr_addr);
  assign rd_idx = reg_of(rd_addr);
  // Read-only status words refuse writes; control frozen while busy
  assign wr_err = (wr_idx == RI_NONE) || (wr_idx == RI_STATUS) ||
                  ((wr_idx == RI_CTRL) && chg_busy);
  assign rd_err = (rd_idx == RI_NONE);

  // --------------------------------------------------------------------
  // Status capture
  // --------------------------------------------------------------------
  lts_phase_t phase_r, phase_nxt;
  logic link_up_prev_r;
  assign phase_nxt = phase_of(core_fsm_state_i);

  // Registered copy of the core state, idle values in reset
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
    begin
      link_up_o <= 1'b0;
      training_fsm_state_o <= FSM_DET_QUIET;
      rx_low_power_state_o <= RX_LP_OFF;
      tx_low_power_state_o <= TX_LP_OFF;
      phase_r <= PH_DETECT;
    end
    else
    begin
      link_up_o <= core_link_up_i;
      training_fsm_state_o <= core_fsm_state_i;
      rx_low_power_state_o <= core_rx_lp_i;
      tx_low_power_state_o <= core_tx_lp_i;
      phase_r <= phase_nxt;
    end

  // Lane count forced to x1 code while link is down, never stale
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
      current_lane_count_o <= LANES_X1;
    else if (core_link_up_i)
      current_lane_count_o <= core_lane_count_i;
    else
      current_lane_count_o <= LANES_X1;

  assign link_phase_o = phase_r;

  // Link-up history for the drop flag
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
      link_up_prev_r <= 1'b0;
    else
      link_up_prev_r <= link_up_o;

  // --------------------------------------------------------------------
  // Event counters
  // --------------------------------------------------------------------
  logic [CNT_W-1:0] recov_cnt_r, l0s_cnt_r;
  logic recov_evt, l0s_evt, recov_clr, l0s_clr;
  // Entry into recovery from any other phase
  assign recov_evt = (phase_nxt == PH_RECOVERY) &&
                     (phase_r != PH_RECOVERY);
  // Transmitter leaving the not-in-L0s code
  assign l0s_evt = (core_tx_lp_i != TX_LP_OFF) &&
                   (tx_low_power_state_o == TX_LP_OFF);
  assign recov_clr = wr_en && (wr_idx == RI_RECOV);
  assign l0s_clr = wr_en && (wr_idx == RI_L0S);

  // Clear and count together leave a count of one, no event lost
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
      recov_cnt_r <= '0;
    else if (recov_clr)
      recov_cnt_r <= recov_evt ? CNT_W'(1) : '0;
    else if (recov_evt && (recov_cnt_r != '1))
      recov_cnt_r <= recov_cnt_r + CNT_W'(1);

  // Same scheme for transmitter low-power entries; both saturate
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
      l0s_cnt_r <= '0;
    else if (l0s_clr)
      l0s_cnt_r <= l0s_evt ? CNT_W'(1) : '0;
    else if (l0s_evt && (l0s_cnt_r != '1))
      l0s_cnt_r <= l0s_cnt_r + CNT_W'(1);

  // --------------------------------------------------------------------
  // Directed change control word
  // --------------------------------------------------------------------
  logic [8:0] ctrl_r, ctrl_nxt;
  logic ctrl_wr, chg_start;
  assign ctrl_wr = wr_en && (wr_idx == RI_CTRL) && !wr_err;

  // Byte-lane merge of the control word
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    if (wr_strb[0])
      ctrl_nxt[7:0] = wr_data[7:0];
    if (wr_strb[1])
      ctrl_nxt[8] = wr_data[CT_REASON_BIT];
  end

  // Control word; whole operation latched in one write
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
      ctrl_r <= CTRL_RST;
    else if (ctrl_wr)
      ctrl_r <= ctrl_nxt;

  // A write with a non-zero request kind launches a change if the link is up
  assign chg_start = ctrl_wr &&
    (ctrl_nxt[CT_REQ_LSB +: 2] != CHG_NONE);

  lts_change_ctl u_chg
  (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .start_i(chg_start),
    .kind_i(ctrl_nxt[CT_REQ_LSB +: 2]),
    .link_up_i(link_up_o),
    .core_done_i(core_change_done_i),
    .request_o(chg_request),
    .busy_o(chg_busy),
    .done_o(chg_done),
    .abort_o(chg_abort),
    .refused_o(chg_refused)
  );

  // Target and reason come from the frozen word, so they stay consistent
  assign directed_change_request_o = chg_request;
  assign directed_target_rate_o = ctrl_r[CT_RATE_BIT];
  assign directed_target_lanes_o = ctrl_r[CT_LANES_LSB +: 2];
  assign directed_change_reason_o = ctrl_r[8];

  // Completion pulse, registered for the user side
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
      directed_change_finished_o <= 1'b0;
    else
      directed_change_finished_o <= chg_done;

  // --------------------------------------------------------------------
  // Sticky change flags, write one to clear
  // --------------------------------------------------------------------
  logic [4:1] flag_r, flag_set, flag_clr;
  assign flag_set = {link_up_prev_r && !link_up_o, chg_abort,
                     chg_refused, chg_done};
  assign flag_clr = (wr_en && (wr_idx == RI_CHG) && wr_strb[0]) ?
                    wr_data[4:1] : 4'h0;

  // Set wins over a clear in the same cycle
  generate
    for (genvar i = 1; i <= 4; i++)
    begin : g_flag
      always_ff @(posedge clk_i or negedge nrst_i)
        if (!nrst_i)
          flag_r[i] <= 1'b0;
        else if (flag_set[i])
          flag_r[i] <= 1'b1;
        else if (flag_clr[i])
          flag_r[i] <= 1'b0;
    end
  endgenerate

  // --------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------
  always_comb
  begin
    rd_data = 32'h0000_0000;
    unique case (rd_idx)
      RI_STATUS:
      begin
        rd_data[ST_FSM_LSB +: 6] = training_fsm_state_o;
        rd_data[ST_LANES_LSB +: 2] = current_lane_count_o;
        rd_data[ST_RXLP_LSB +: 2] = rx_low_power_state_o;
        rd_data[ST_TXLP_LSB +: 3] = tx_low_power_state_o;
        rd_data[ST_PHASE_LSB +: 4] = phase_r;
        rd_data[ST_LINKUP_BIT] = link_up_o;
      end
      RI_CTRL:
      begin
        rd_data[7:0] = ctrl_r[7:0];
        rd_data[CT_REASON_BIT] = ctrl_r[8];
      end
      RI_CHG:
      begin
        rd_data[CG_BUSY_BIT] = chg_busy;
        rd_data[CG_LINKDROP_BIT:CG_DONE_BIT] = flag_r;
      end
      RI_RECOV:
        rd_data[CNT_W-1:0] = recov_cnt_r;
      RI_L0S:
        rd_data[CNT_W-1:0] = l0s_cnt_r;
      RI_NONE:
        rd_data = 32'h0000_0000;
      default:
        rd_data = 32'h0000_0000;
    endcase
  end
endmodule

/* lts_report_assertions.sv */
// Purpose: Port timing checks for the link status report
// Assumes: Status outputs copy core inputs one edge later
// Notes: Phase decode is checked against the registered state for the RP configuration codes only
`timescale 1ns/1ps
module lts_report_chk
  import lts_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic core_link_up_i,
  input wire logic [1:0] core_lane_count_i,
  input wire logic [5:0] core_fsm_state_i,
  input wire logic [1:0] core_rx_lp_i,
  input wire logic [2:0] core_tx_lp_i,
  input wire logic core_change_done_i,
  input wire logic link_up_o,
  input wire logic [1:0] current_lane_count_o,
  input wire logic [5:0] training_fsm_state_o,
  input wire logic [1:0] rx_low_power_state_o,
  input wire logic [2:0] tx_low_power_state_o,
  input wire logic [3:0] link_phase_o,
  input wire logic [1:0] directed_change_request_o,
  input wire logic directed_target_rate_o,
  input wire logic [1:0] directed_target_lanes_o,
  input wire logic directed_change_reason_o,
  input wire logic directed_change_finished_o
);
  // One domain; $past guard skips the edge that leaves reset
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  property p_lane; $past(nrst_i) |-> current_lane_count_o ==
    ($past(core_link_up_i) ? $past(core_lane_count_i) : LANES_X1);
  endproperty
  a_lane: assert property (p_lane) else $error("lane count");
  property p_fsm; $past(nrst_i) |->
    training_fsm_state_o == $past(core_fsm_state_i); endproperty
  a_fsm: assert property (p_fsm) else $error("fsm state");
  property p_rx; $past(nrst_i) |->
    rx_low_power_state_o == $past(core_rx_lp_i); endproperty
  a_rx: assert property (p_rx) else $error("rx state");
  property p_tx; $past(nrst_i) |->
    tx_low_power_state_o == $past(core_tx_lp_i); endproperty
  a_tx: assert property (p_tx) else $error("tx state");
  property p_rp; training_fsm_state_o inside
    {[FSM_RP_CFG_FIRST:FSM_RP_CFG_LAST]} |-> link_phase_o == PH_CONFIG;
  endproperty
  a_rp: assert property (p_rp) else $error("rp phase");
  property p_fin; core_change_done_i && directed_change_request_o !=
    CHG_NONE |-> ##[1:3] directed_change_finished_o; endproperty
  a_fin: assert property (p_fin) else $error("no finish");
  property p_drop; !link_up_o |=>
    directed_change_request_o == CHG_NONE; endproperty
  a_drop: assert property (p_drop) else $error("req w/o link");
  property p_tgt; directed_change_request_o != CHG_NONE |=> $stable(
    {directed_target_rate_o, directed_target_lanes_o,
    directed_change_reason_o}); endproperty
  a_tgt: assert property (p_tgt) else $error("target moved");
endmodule
bind lts_report lts_report_chk u_chk (.*);

/* lts_core_model.sv */
// Purpose: Physical layer stand-in that finishes directed changes
// Assumes: Request is a level held until done is seen
// Notes: Done stays high while the request stays up
`timescale 1ns/1ps
module lts_core_model
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [1:0] request_i,
  input wire logic [3:0] lag_i,
  output logic done_o
);
  logic [3:0] cnt_r;
  // Count the lag while a request level stands
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i) cnt_r <= 4'h0;
    else if (request_i == 2'b00) cnt_r <= 4'h0;
    else if (cnt_r != lag_i) cnt_r <= cnt_r + 4'h1;
  // Level done, released with the request
  assign done_o = (request_i != 2'b00) && (cnt_r == lag_i);
endmodule

/* lts_report_tb.sv */
// Purpose: Self-checking bench for the link status report
// Assumes: Register offsets and fields from the shared package
// Notes: Waits are bounded; a timeout counts as a failure
`timescale 1ns/1ps
module lts_report_tb;
  import lts_pkg::*;
  logic clk_i = 0, nrst_i = 0;
  logic [7:0] s_axil_awaddr_i = 0, s_axil_araddr_i = 0;
  logic [31:0] s_axil_wdata_i = 0, s_axil_rdata_o;
  logic [3:0] s_axil_wstrb_i = 4'hf;
  logic s_axil_awvalid_i = 0, s_axil_wvalid_i = 0, s_axil_bready_i = 0;
  logic s_axil_arvalid_i = 0, s_axil_rready_i = 0, s_axil_awready_o;
  logic s_axil_wready_o, s_axil_bvalid_o, s_axil_arready_o;
  logic s_axil_rvalid_o, link_up_o, directed_target_rate_o;
  logic [1:0] s_axil_bresp_o, s_axil_rresp_o, current_lane_count_o;
  logic core_link_up_i = 1, core_change_done_i, directed_change_reason_o;
  logic [1:0] core_lane_count_i = 3, core_rx_lp_i = 3;
  logic [5:0] core_fsm_state_i = 6'h16, training_fsm_state_o;
  logic [2:0] core_tx_lp_i = 5, tx_low_power_state_o;
  logic [1:0] rx_low_power_state_o, directed_change_request_o;
  logic [1:0] directed_target_lanes_o;
  logic [3:0] link_phase_o, lag = 0;
  logic directed_change_finished_o;
  logic [5:0] st_v[6] = '{6'h16, 6'h21, 6'h26, 6'h2d, 6'h32, 6'h33};
  logic [3:0] ph_v[6] = '{4'h4, 4'h7, 4'h3, 4'h9, 4'ha, 4'hf};
  int failures = 0, samples_checked = 0;
  lts_report DUT (.*);
  lts_core_model core_model (.clk_i(clk_i), .nrst_i(nrst_i),
    .request_i(directed_change_request_o), .lag_i(lag),
    .done_o(core_change_done_i));
  // 250 MHz clock
  always #2 clk_i = ~clk_i;
  // ------------------------------------------------------------
  // Bus and check helpers
  // ------------------------------------------------------------
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      failures++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 60)
    begin
      failures++;
      $display("ERROR t=%0t wait timed out", $time);
      report_and_stop();
    end
  endtask
  // Releases each channel at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er);
    int n;
    n = 0;
    s_axil_awaddr_i <= a;
    s_axil_wdata_i <= d;
    s_axil_awvalid_i <= 1'b1;
    s_axil_wvalid_i <= 1'b1;
    s_axil_bready_i <= 1'b1;
    do
    begin
      @(posedge clk_i);
      n++;
      if (s_axil_awready_o) s_axil_awvalid_i <= 1'b0;
      if (s_axil_wready_o) s_axil_wvalid_i <= 1'b0;
    end
    while (!s_axil_bvalid_o && n < 60);
    s_axil_bready_i <= 1'b0;
    tmo(n);
    cmp(s_axil_bresp_o, er);
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
    input logic [1:0] er);
    int n;
    n = 0;
    s_axil_araddr_i <= a;
    s_axil_arvalid_i <= 1'b1;
    s_axil_rready_i <= 1'b1;
    do
    begin
      @(posedge clk_i);
      n++;
      if (s_axil_arready_o) s_axil_arvalid_i <= 1'b0;
    end
    while (!s_axil_rvalid_o && n < 60);
    s_axil_rready_i <= 1'b0;
    tmo(n);
    cmp(s_axil_rdata_o, e);
    cmp(s_axil_rresp_o, er);
    @(posedge clk_i);
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Main sequence; inputs stay busy during reset on purpose
  initial
  begin
    repeat (2) @(posedge clk_i);
    cmp({link_up_o, current_lane_count_o, training_fsm_state_o,
      link_phase_o, directed_change_request_o}, 0);
    cmp({rx_low_power_state_o, tx_low_power_state_o}, 0);
    nrst_i <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      core_lane_count_i <= i[1:0];
      repeat (2) @(posedge clk_i);
      cmp(current_lane_count_o, i);
    end
    core_link_up_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    cmp(current_lane_count_o, 0);
    core_link_up_i <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      core_fsm_state_i <= st_v[i];
      repeat (2) @(posedge clk_i);
      cmp({training_fsm_state_o, link_phase_o}, {st_v[i], ph_v[i]});
    end
    cmp({rx_low_power_state_o, tx_low_power_state_o}, 5'h1d);
    rd(OFF_STATUS, 32'h01f5_3333, RESP_OKAY);
    rd(OFF_L0S, 32'h1, RESP_OKAY);
    wr(OFF_STATUS, 32'h0, RESP_SLVERR);
    rd(8'h3c, 32'h0, RESP_SLVERR);
    core_fsm_state_i <= FSM_L0;
    for (int k = 1; k < 4; k++)
    begin
      lag <= 4'(10 + k);
      wr(OFF_CTRL, (k[0] << 8) | (k << 4) | (k[1] << 2) | k, 0);
      cmp({directed_change_request_o, directed_target_rate_o,
        directed_target_lanes_o, directed_change_reason_o},
        {k[1:0], k[1], k[1:0], k[0]});
      wr(OFF_CTRL, 32'h0, RESP_SLVERR);
      wait_fin();
      cmp(directed_change_request_o, 0);
      rd(OFF_CHG, k == 1 ? 32'h12 : 32'h2, RESP_OKAY);
      wr(OFF_CHG, 32'h1e, RESP_OKAY);
    end
    core_link_up_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    wr(OFF_CTRL, 32'h1, RESP_OKAY);
    cmp(directed_change_request_o, 0);
    core_link_up_i <= 1'b1;
    lag <= 4'hf;
    repeat (2) @(posedge clk_i);
    wr(OFF_CTRL, 32'h3, RESP_OKAY);
    cmp(directed_change_request_o, 3);
    core_link_up_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    cmp(directed_change_request_o, 0);
    rd(OFF_CHG, 32'h1c, RESP_OKAY);
    report_and_stop();
  end
  task automatic wait_fin();
    int n;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (directed_change_finished_o !== 1'b1 && n < 60);
    tmo(n);
  endtask
endmodule
